// File: mmb_consts.svh
// address map, register offsets and timing constants of the memory map and boot decode block
`ifndef MMB_CONSTS_SVH
`define MMB_CONSTS_SVH

`define MMB_RAM_TOP 24'h00_FFFF
`define MMB_EXT0_BASE 24'h01_0000
`define MMB_EXT1_BASE 24'h40_0000
`define MMB_EXT2_BASE 24'h80_0000
`define MMB_EXT3_BASE 24'hC0_0000
`define MMB_ROM_BASE 24'hFF_8000
`define MMB_ROM_LOADER 24'hFF_8000
`define MMB_ROM_REVISION 24'hFF_ECAE
`define MMB_ROM_BRANCH 24'hFF_ECB0
`define MMB_ROM_SINE 24'hFF_ED00
`define MMB_ROM_RESERVED 24'hFF_EF00
`define MMB_ROM_VECTORS 24'hFF_FF00
`define MMB_BOOT_NOROM_A 3'h0
`define MMB_BOOT_NOROM_B 3'h4
`define MMB_ROM_FIRST_CYC 3'h4
`define MMB_ROM_NEXT_CYC 3'h2
`define MMB_REG_STATUS3 4'h0
`define MMB_REG_BOOT 4'h4
`define MMB_BIT_ROMDIS 0
`define MMB_BIT_CEN 1
`define MMB_BIT_FREEZE 2
`define MMB_BIT_FLUSH 3

`endif

// File: mmb_pkg.sv
// types shared by the memory map and boot decode block
package mmb_pkg;
    typedef enum logic [2:0] {RG_RAM, RG_ROM, RG_EXT0, RG_EXT1, RG_EXT2, RG_EXT3} mmb_region_t;
    typedef enum logic [2:0] {BOOT_ASYNC16, BOOT_SERIAL_EPROM, BOOT_SERIAL_PORT, BOOT_EXT_COPY,
        BOOT_ASYNC32, BOOT_HOST_PORT, BOOT_TWO_WIRE, BOOT_UART} mmb_boot_t;
    typedef enum logic [2:0] {SEC_LOADER, SEC_REVISION, SEC_BRANCH, SEC_SINE, SEC_RESERVED,
        SEC_VECTORS, SEC_NONE} mmb_rom_sec_t;
    typedef enum {ROM_IDLE, ROM_BUSY, ROM_DONE} mmb_rom_state_t;
    typedef enum {IC_IDLE, IC_FILL, IC_DONE} mmb_ic_state_t;
endpackage

// File: mmb_memory_map.sv
// memory map decode, boot strap latch, rom, dual access ram and instruction cache
//
// Local design decisions: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`include "mmb_consts.svh"
// Function
// - boot strap pins are captured when hardware reset is released and held
// - boot code 0..7 names the eight boot processes in documented order
// - rom disable bit is set for strap code 0 or 4, cleared otherwise
// - with rom enabled, FF8000h..FFFFFFh decodes to on-chip rom
// - with rom disabled, top 32K bytes go to external space
// - straps are not sampled again until the next hardware reset
// - software reset leaves the rom disable bit unchanged
// - software may set or clear rom disable; decode follows at once
// - rom serves the program bus and both read data buses
// - rom read takes four cycles for a first word, two per following word
// - rom image sections: loader, revision, branch table, sine, reserved, vectors
// - eight 4K-word ram blocks, each taking two accesses per cycle
// - ram at 000000h..00FFFFh, one block per 2000h bytes from zero
// - ram reachable from program, data and dma buses
// - host port denied all ram access while device is in reset
// - two-way cache, 512 sets, lines of four 32-bit words, tag per line
// - cache replaces the least recently used line of a set
// - status bits enable, freeze and flush the cache
// - one address space: an address reaches one location from any bus
// - external spaces start at 010000h, 400000h, 800000h, C00000h
// - rom enabled takes top 32K bytes of space three, else full 4M
// - straps share gpio pins 2..0 and act as straps only at the latch
module mmb_memory_map #(
    parameter int SETS = 512,
    parameter int ROM_WORDS = 16384
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [2:0] gpio_pins_in,
    input wire logic sw_reset,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [23:0] dec_addr,
    output mmb_pkg::mmb_region_t dec_region,
    output logic [3:0] dec_ext_sel,
    input wire logic pa_en,
    input wire logic pa_we,
    input wire logic [23:0] pa_addr,
    input wire logic [15:0] pa_wdata,
    output logic [15:0] pa_rdata,
    input wire logic pb_en,
    input wire logic pb_we,
    input wire logic pb_host,
    input wire logic [23:0] pb_addr,
    input wire logic [15:0] pb_wdata,
    output logic [15:0] pb_rdata,
    output logic pb_denied,
    input wire logic [2:0] rom_req,
    input wire logic [71:0] rom_addr,
    output logic [2:0] rom_ack,
    output logic [15:0] rom_rdata,
    output mmb_pkg::mmb_rom_sec_t rom_section,
    input wire logic rom_load_we,
    input wire logic [13:0] rom_load_addr,
    input wire logic [15:0] rom_load_data,
    input wire logic ic_req,
    input wire logic [23:0] ic_addr,
    output logic ic_ack,
    output logic ic_hit,
    output logic [31:0] ic_data,
    output logic fill_req,
    output logic [23:0] fill_addr,
    input wire logic fill_valid,
    input wire logic [31:0] fill_data,
    output mmb_pkg::mmb_boot_t boot_mode,
    output logic rom_disable
);
    import mmb_pkg::*;

    // ************************************************
    // status register three and boot strap latch
    // ************************************************
    logic rom_map_disable_bit_q;
    logic boot_seen_q;
    mmb_boot_t boot_mode_q;
    logic cache_en_q;
    logic freeze_q;
    logic flush_q;
    logic av_ack_q;
    logic [31:0] rdata_q;
    logic av_wr;

    assign av_wr = avs_write && av_ack_q;
    assign avs_waitrequest = (avs_read || avs_write) && !av_ack_q;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            av_ack_q <= 1'b0;
        end else begin
            av_ack_q <= (avs_read || avs_write) && !av_ack_q;
        end
    end

    // first edge after release catches the gpio pads as straps, later edges never look again
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            boot_seen_q <= 1'b0;
            boot_mode_q <= BOOT_ASYNC16;
        end else if (!boot_seen_q) begin
            boot_seen_q <= 1'b1;
            boot_mode_q <= mmb_boot_t'(gpio_pins_in);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rom_map_disable_bit_q <= 1'b0;
        end else if (!boot_seen_q) begin
            rom_map_disable_bit_q <= (gpio_pins_in == `MMB_BOOT_NOROM_A)
                || (gpio_pins_in == `MMB_BOOT_NOROM_B);
        end else if (av_wr && avs_address == `MMB_REG_STATUS3) begin
            rom_map_disable_bit_q <= avs_writedata[`MMB_BIT_ROMDIS];
        end
    end

    // software reset clears cache control only; the rom mapping survives it
    always_ff @(posedge core_clk) begin
        if (!rst_n || sw_reset) begin
            cache_en_q <= 1'b0;
            freeze_q <= 1'b0;
        end else if (av_wr && avs_address == `MMB_REG_STATUS3) begin
            cache_en_q <= avs_writedata[`MMB_BIT_CEN];
            freeze_q <= avs_writedata[`MMB_BIT_FREEZE];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            flush_q <= 1'b0;
        end else begin
            flush_q <= av_wr && avs_address == `MMB_REG_STATUS3 && avs_writedata[`MMB_BIT_FLUSH];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read && !av_ack_q) begin
            case (avs_address)
                `MMB_REG_STATUS3: rdata_q <= {28'h000_0000, 1'b0, freeze_q, cache_en_q, rom_map_disable_bit_q};
                `MMB_REG_BOOT: rdata_q <= {29'h0000_0000, boot_mode_q};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign avs_readdata = rdata_q;
    assign boot_mode = boot_mode_q;
    assign rom_disable = rom_map_disable_bit_q;

    // ************************************************
    // unified address decode
    // ************************************************
    // one function for every bus keeps program and data views identical
    function automatic mmb_region_t decode(input logic [23:0] a, input logic dis);
        if (a <= `MMB_RAM_TOP) begin
            decode = RG_RAM;
        end else if (!dis && a >= `MMB_ROM_BASE) begin
            decode = RG_ROM;
        end else begin
            decode = mmb_region_t'({1'b0, a[23:22]} + 3'h2);
        end
    endfunction

    mmb_region_t dec_region_q;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dec_region_q <= RG_RAM;
        end else begin
            dec_region_q <= decode(dec_addr, rom_map_disable_bit_q);
        end
    end

    assign dec_region = dec_region_q;
    assign dec_ext_sel = {dec_region_q == RG_EXT3, dec_region_q == RG_EXT2,
        dec_region_q == RG_EXT1, dec_region_q == RG_EXT0};

    // ************************************************
    // dual access ram, eight blocks
    // ************************************************
    logic a_hit;
    logic b_hit;
    logic [15:0] a_rd [8];
    logic [15:0] b_rd [8];
    logic [2:0] a_blk_q;
    logic [2:0] b_blk_q;
    logic pb_denied_q;

    assign a_hit = pa_en && decode(pa_addr, rom_map_disable_bit_q) == RG_RAM;
    assign b_hit = pb_en && decode(pb_addr, rom_map_disable_bit_q) == RG_RAM && !(pb_host && !rst_n);

    genvar g;
    for (g = 0; g < 8; g++) begin : g_blk
        logic [15:0] mem [4096];
        logic [15:0] ra_q;
        logic [15:0] rb_q;
        // two ports per block per cycle; on a double write to one word port a lands last
        always_ff @(posedge core_clk) begin
            if (b_hit && pb_addr[15:13] == 3'(g)) begin
                if (pb_we) begin
                    mem[pb_addr[12:1]] <= pb_wdata;
                end
                rb_q <= mem[pb_addr[12:1]];
            end
            if (a_hit && pa_addr[15:13] == 3'(g)) begin
                if (pa_we) begin
                    mem[pa_addr[12:1]] <= pa_wdata;
                end
                ra_q <= mem[pa_addr[12:1]];
            end
        end
        assign a_rd[g] = ra_q;
        assign b_rd[g] = rb_q;
    end

    always_ff @(posedge core_clk) begin
        a_blk_q <= pa_addr[15:13];
        b_blk_q <= pb_addr[15:13];
        pb_denied_q <= pb_en && pb_host && !rst_n;
    end

    assign pa_rdata = a_rd[a_blk_q];
    assign pb_rdata = b_rd[b_blk_q];
    assign pb_denied = pb_denied_q;

    // ************************************************
    // rom engine, program bus and both read buses
    // ************************************************
    logic [15:0] rom_mem [ROM_WORDS];
    mmb_rom_state_t rom_st_q;
    logic [1:0] rom_gnt_q;
    logic [2:0] rom_cnt_q;
    logic [23:0] rom_last_q;
    logic rom_stream_q;
    logic [2:0] rom_ack_q;
    logic [15:0] rom_rdata_q;
    mmb_rom_sec_t rom_sec_q;
    logic [1:0] sel;
    logic [23:0] sel_addr;
    logic [2:0] rom_live;
    logic rom_seq;
    logic rom_go;

    // a request outside the rom window is not this engine's to answer
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            rom_live[i] = rom_req[i] && decode(rom_addr[i*24 +: 24], rom_map_disable_bit_q) == RG_ROM;
        end
        sel = rom_live[0] ? 2'd0 : (rom_live[1] ? 2'd1 : 2'd2);
        sel_addr = rom_addr[sel*24 +: 24];
        rom_go = rom_st_q == ROM_IDLE && rom_live != 3'h0;
        rom_seq = rom_stream_q && rom_gnt_q == sel && sel_addr == rom_last_q + 24'h00_0002;
    end

    function automatic mmb_rom_sec_t section(input logic [23:0] a);
        if (a >= `MMB_ROM_VECTORS) section = SEC_VECTORS;
        else if (a >= `MMB_ROM_RESERVED) section = SEC_RESERVED;
        else if (a >= `MMB_ROM_SINE) section = SEC_SINE;
        else if (a >= `MMB_ROM_BRANCH) section = SEC_BRANCH;
        else if (a >= `MMB_ROM_REVISION) section = SEC_REVISION;
        else if (a >= `MMB_ROM_LOADER) section = SEC_LOADER;
        else section = SEC_NONE;
    endfunction

    // the mask image is written once through the load port; the cpu side only reads it
    always_ff @(posedge core_clk) begin
        if (rom_load_we) begin
            rom_mem[rom_load_addr] <= rom_load_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rom_st_q <= ROM_IDLE;
            rom_cnt_q <= 3'h0;
            rom_gnt_q <= 2'd0;
            rom_last_q <= 24'h00_0000;
            rom_stream_q <= 1'b0;
            rom_ack_q <= 3'h0;
            rom_rdata_q <= 16'h0000;
            rom_sec_q <= SEC_NONE;
        end else begin
            rom_ack_q <= 3'h0;
            case (rom_st_q)
                ROM_IDLE: begin
                    if (rom_go) begin
                        rom_st_q <= ROM_BUSY;
                        rom_cnt_q <= (rom_seq ? `MMB_ROM_NEXT_CYC : `MMB_ROM_FIRST_CYC) - 3'h1;
                        rom_gnt_q <= sel;
                        rom_last_q <= sel_addr;
                    end else begin
                        rom_stream_q <= 1'b0;
                    end
                end
                ROM_BUSY: begin
                    if (rom_cnt_q == 3'h0) begin
                        rom_st_q <= ROM_DONE;
                        rom_ack_q[rom_gnt_q] <= 1'b1;
                        rom_rdata_q <= rom_mem[rom_last_q[14:1]];
                        rom_sec_q <= section(rom_last_q);
                        rom_stream_q <= 1'b1;
                    end else begin
                        rom_cnt_q <= rom_cnt_q - 3'h1;
                    end
                end
                ROM_DONE: rom_st_q <= ROM_IDLE;
                default: rom_st_q <= ROM_IDLE;
            endcase
        end
    end

    assign rom_ack = rom_ack_q;
    assign rom_rdata = rom_rdata_q;
    assign rom_section = rom_sec_q;

    // ************************************************
    // two-way instruction cache
    // ************************************************
    localparam int IW = $clog2(SETS);
    localparam int TW = 24 - 4 - IW;
    logic [TW-1:0] tag_mem [2][SETS];
    logic [127:0] line_mem [2][SETS];
    logic [1:0] valid_q [SETS];
    logic lru_q [SETS];
    mmb_ic_state_t ic_st_q;
    logic [1:0] beat_q;
    logic [127:0] fill_buf_q;
    logic [23:0] ic_addr_q;
    logic ic_ack_q;
    logic ic_hit_q;
    logic [31:0] ic_data_q;
    logic [IW-1:0] set_i;
    logic [IW-1:0] set_q;
    logic [TW-1:0] tag_i;
    logic [1:0] way_hit;
    logic victim;

    assign set_i = ic_addr[4 +: IW];
    assign set_q = ic_addr_q[4 +: IW];
    assign tag_i = ic_addr[23 -: TW];
    assign way_hit[0] = cache_en_q && valid_q[set_i][0] && tag_mem[0][set_i] == tag_i;
    assign way_hit[1] = cache_en_q && valid_q[set_i][1] && tag_mem[1][set_i] == tag_i;
    assign victim = lru_q[set_q];

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ic_st_q <= IC_IDLE;
            beat_q <= 2'd0;
            ic_ack_q <= 1'b0;
            ic_hit_q <= 1'b0;
            ic_data_q <= 32'h0000_0000;
            ic_addr_q <= 24'h00_0000;
            fill_buf_q <= '0;
        end else begin
            ic_ack_q <= 1'b0;
            case (ic_st_q)
                IC_IDLE: begin
                    if (ic_req && way_hit != 2'b00) begin
                        ic_st_q <= IC_DONE;
                        ic_ack_q <= 1'b1;
                        ic_hit_q <= 1'b1;
                        ic_data_q <= line_mem[way_hit[1]][set_i][ic_addr[3:2]*32 +: 32];
                    end else if (ic_req) begin
                        ic_st_q <= IC_FILL;
                        ic_addr_q <= ic_addr;
                        beat_q <= 2'd0;
                    end
                end
                IC_FILL: begin
                    if (fill_valid) begin
                        fill_buf_q[beat_q*32 +: 32] <= fill_data;
                        beat_q <= beat_q + 2'd1;
                        if (beat_q == ic_addr_q[3:2]) begin
                            ic_data_q <= fill_data;
                        end
                        if (beat_q == 2'd3) begin
                            ic_st_q <= IC_DONE;
                            ic_ack_q <= 1'b1;
                            ic_hit_q <= 1'b0;
                        end
                    end
                end
                IC_DONE: ic_st_q <= IC_IDLE;
                default: ic_st_q <= IC_IDLE;
            endcase
        end
    end

    // a frozen or disabled cache still fetches but neither allocates nor ages its sets
    always_ff @(posedge core_clk) begin
        if (ic_st_q == IC_FILL && fill_valid && beat_q == 2'd3 && cache_en_q && !freeze_q) begin
            tag_mem[victim][set_q] <= ic_addr_q[23 -: TW];
            line_mem[victim][set_q] <= {fill_data, fill_buf_q[95:0]};
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n || flush_q) begin
            for (int s = 0; s < SETS; s++) begin
                valid_q[s] <= 2'b00;
                lru_q[s] <= 1'b0;
            end
        end else if (!freeze_q && cache_en_q) begin
            if (ic_st_q == IC_IDLE && ic_req && way_hit != 2'b00) begin
                lru_q[set_i] <= !way_hit[1];
            end else if (ic_st_q == IC_FILL && fill_valid && beat_q == 2'd3) begin
                valid_q[set_q][victim] <= 1'b1;
                lru_q[set_q] <= !victim;
            end
        end
    end

    assign ic_ack = ic_ack_q;
    assign ic_hit = ic_hit_q;
    assign ic_data = ic_data_q;
    assign fill_req = ic_st_q == IC_FILL;
    assign fill_addr = {ic_addr_q[23:4], 4'h0};

    // ************************************************
    // checks
    // ************************************************
    sequence s_first_word;
        rom_st_q == ROM_BUSY [*4] ##1 rom_ack != 3'h0;
    endsequence
    sequence s_next_word;
        rom_st_q == ROM_BUSY [*2] ##1 rom_ack != 3'h0;
    endsequence

    property p_strap_latch;
        @(posedge core_clk) disable iff (!rst_n)
        $rose(boot_seen_q) |-> boot_mode_q == $past(gpio_pins_in)
            && rom_disable == ($past(gpio_pins_in) == 3'h0 || $past(gpio_pins_in) == 3'h4);
    endproperty
    a_strap_latch: assert property (p_strap_latch) else $error("strap capture wrong");
    property p_strap_hold;
        @(posedge core_clk) disable iff (!rst_n) $past(boot_seen_q) |-> $stable(boot_mode_q);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("boot mode changed");
    property p_swrst_keep;
        @(posedge core_clk) disable iff (!rst_n) boot_seen_q && sw_reset && !av_wr |=> $stable(rom_disable);
    endproperty
    a_swrst_keep: assert property (p_swrst_keep) else $error("sw reset hit rom bit");
    property p_sw_write;
        @(posedge core_clk) disable iff (!rst_n)
        boot_seen_q && av_wr && avs_address == 4'h0 |=> rom_disable == $past(avs_writedata[0]);
    endproperty
    a_sw_write: assert property (p_sw_write) else $error("rom bit write lost");
    property p_rom_map;
        @(posedge core_clk) disable iff (!rst_n)
        dec_addr >= 24'hFF_8000 |=> dec_region == ($past(rom_disable) ? RG_EXT3 : RG_ROM);
    endproperty
    a_rom_map: assert property (p_rom_map) else $error("rom window decode");
    property p_ram_map;
        @(posedge core_clk) disable iff (!rst_n) dec_addr < 24'h01_0000 |=> dec_region == RG_RAM;
    endproperty
    a_ram_map: assert property (p_ram_map) else $error("ram decode");
    property p_ext_map;
        @(posedge core_clk) disable iff (!rst_n) dec_addr >= 24'h01_0000 && dec_addr < 24'hC0_0000
            |=> dec_ext_sel == 4'(1 << $past(dec_addr[23:22]));
    endproperty
    a_ext_map: assert property (p_ext_map) else $error("external space decode");
    property p_host_deny;
        @(posedge core_clk) disable iff (!rst_n) $rose(rst_n) && $past(pb_en && pb_host) |-> pb_denied;
    endproperty
    a_host_deny: assert property (p_host_deny) else $error("host not denied");
    property p_rom_first;
        @(posedge core_clk) disable iff (!rst_n) rom_go && !rom_seq |=> s_first_word;
    endproperty
    a_rom_first: assert property (p_rom_first) else $error("rom first word timing");
    property p_rom_next;
        @(posedge core_clk) disable iff (!rst_n) rom_go && rom_seq |=> s_next_word;
    endproperty
    a_rom_next: assert property (p_rom_next) else $error("rom next word timing");
endmodule

// File: mmb_fill_model.sv
// line fill responder standing in for external program memory
`timescale 1ns/1ps
module mmb_fill_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic fill_req,
    input wire logic [23:0] fill_addr,
    output logic fill_valid = 1'b0,
    output logic [31:0] fill_data = '0
);
    int n = 0;
    int d;
    // a slow memory stalls before its first beat
    assign d = slow ? 5 : 0;
    // ************************************
    // four beats, word 0 first
    // ************************************
    always @(posedge core_clk) begin
        fill_valid <= rst_n && fill_req === 1'b1 && n >= d && n < d + 4;
        if (rst_n && fill_req === 1'b1 && n >= d && n < d + 4)
            fill_data <= {8'h00, fill_addr} + 32'(n - d);
        else
            // no beat on the bus: invert the previous value, so junk alternates with the last word
            fill_data <= ~fill_data;
        if (!rst_n || fill_req !== 1'b1)
            n <= 0;
        else
            n <= n + 1;
    end
endmodule

// File: memory_map_boot_decode_bench.sv
// self-checking bench for the memory map and boot decode block
`timescale 1ns/1ps
`include "mmb_consts.svh"
module memory_map_boot_decode_bench;
    import mmb_pkg::*;
    logic core_clk = 0, rst_n = 0, sw_reset = 0, slow = 0, avs_read = 0, avs_write = 0;
    logic pa_en = 0, pa_we = 0, pb_en = 0, pb_we = 0, pb_host = 0, rom_load_we = 0, ic_req = 0;
    logic fill_valid, avs_waitrequest, pb_denied, ic_ack, ic_hit, fill_req, rom_disable;
    logic [2:0] gpio_pins_in = '0, rom_req = '0, rom_ack;
    logic [3:0] avs_address = '0, dec_ext_sel;
    logic [13:0] rom_load_addr = '0;
    logic [15:0] pa_wdata = '0, pb_wdata = '0, rom_load_data = '0, pa_rdata, pb_rdata, rom_rdata, d;
    logic [23:0] dec_addr = '0, pa_addr = '0, pb_addr = '0, ic_addr = '0, fill_addr, a;
    logic [31:0] avs_writedata = '0, avs_readdata, fill_data, rd, ic_data;
    logic [71:0] rom_addr = '0;
    mmb_region_t dec_region;
    mmb_rom_sec_t rom_section;
    mmb_boot_t boot_mode;
    int compares = 0, miscompares = 0, n;
    bit exp_dis;
    int q[$];
    logic [23:0] al [10] = '{24'h00_0000, 24'h00_FFFF, 24'h01_0000, 24'h3F_FFFF, 24'h40_0000,
        24'h80_0000, 24'hC0_0000, 24'hFF_7FFF, 24'hFF_8000, 24'hFF_FFFF};
    always #5 core_clk = ~core_clk;
    mmb_memory_map dut_u (.*);
    mmb_fill_model fill_u (.core_clk(core_clk), .rst_n(rst_n), .slow(slow), .fill_req(fill_req),
        .fill_addr(fill_addr), .fill_valid(fill_valid), .fill_data(fill_data));
    // ************************************
    // bench tasks
    // ************************************
    task automatic end_of_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("unexpected %0t %s", $time, m);
        end
    endtask
    task automatic tick;
        @(posedge core_clk);
        n++;
    endtask
    task automatic bus(input logic wr, input logic [3:0] ad, input logic [31:0] wd);
        {avs_address, avs_writedata, avs_read, avs_write} <= {ad, wd, !wr, wr};
        do tick(); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        {avs_read, avs_write} <= 2'b00;
        @(posedge core_clk);
    endtask
    task automatic boot(input logic [2:0] c);
        {gpio_pins_in, rst_n, pb_en, pb_host} <= {c, 3'b011};
        repeat (3) @(posedge core_clk);
        chk(pb_denied === 1'b1, "host let in during reset");
        {rst_n, pb_en, pb_host} <= 3'b100;
        repeat (2) @(posedge core_clk);
        gpio_pins_in <= ~c;
        exp_dis = c == 0 || c == 4;
    endtask
    function automatic mmb_region_t exp_rg(input logic [23:0] ad);
        if (ad <= `MMB_RAM_TOP)
            return RG_RAM;
        if (ad >= `MMB_ROM_BASE && !exp_dis)
            return RG_ROM;
        return mmb_region_t'(int'(RG_EXT0) + ad[23:22]);
    endfunction
    task automatic dec(input logic [23:0] ad);
        mmb_region_t e;
        e = exp_rg(ad);
        dec_addr <= ad;
        repeat (2) @(posedge core_clk);
        chk(dec_region === e, "decode");
        chk(dec_ext_sel === (e >= RG_EXT0 ? 4'h1 << (e - RG_EXT0) : 4'h0), "space select");
    endtask
    // ************************************
    // tests
    // ************************************
    initial begin
        #100us;
        // the whole run needs well under a tenth of this
        miscompares++;
        end_of_test();
    end
    initial begin
        void'($urandom(55));
        for (int c = 0; c < 8; c++) begin
            boot(3'(c));
            chk(boot_mode === mmb_boot_t'(c) && rom_disable === exp_dis, "boot latch");
            repeat (2) @(posedge core_clk);
            chk(boot_mode === mmb_boot_t'(c), "straps sampled again");
        end
        $display("boot test done");
        for (int k = 0; k < 3; k++) begin
            for (int i = 0; i < 14; i++)
                dec(i < 10 ? al[i] : 24'($urandom));
            bus(1, `MMB_REG_STATUS3, 32'(k == 0));
            exp_dis = k == 0;
            bus(0, `MMB_REG_STATUS3, '0);
            chk(rd[0] === exp_dis, "status readback");
        end
        bus(1, `MMB_REG_STATUS3, 32'h0000_0001);
        sw_reset <= 1;
        @(posedge core_clk);
        sw_reset <= 0;
        @(posedge core_clk);
        chk(rom_disable === 1'b1, "soft reset");
        bus(0, `MMB_REG_BOOT, '0);
        chk(rd[2:0] === 3'h7, "boot register");
        bus(0, 4'h8, '0);
        chk(rd === 32'h0000_0000, "unmapped read");
        exp_dis = 0;
        bus(1, `MMB_REG_STATUS3, 32'h0000_0002);
        $display("decode test done");
        for (int i = 0; i < 8; i++) begin
            a = 24'(i * 'h2000) + {11'h0, 12'($urandom), 1'b0};
            d = 16'($urandom);
            {pa_en, pa_we, pa_addr, pa_wdata} <= {2'b11, a, d};
            @(posedge core_clk);
            {pa_we, pb_en, pb_addr} <= {2'b01, a};
            repeat (2) @(posedge core_clk);
            chk(pb_rdata === d && pa_rdata === d, "ram block");
            {pa_en, pb_en} <= 2'b00;
            // let an edge pass so the next block's enable is not driven twice in one step
            @(posedge core_clk);
        end
        $display("ram test done");
        for (int i = 0; i < 2; i++) begin
            d = 16'($urandom);
            q.push_back(d);
            {rom_load_we, rom_load_addr, rom_load_data} <= {1'b1, 14'(`MMB_ROM_SINE >> 1) + 14'(i), d};
            @(posedge core_clk);
        end
        rom_load_we <= 0;
        for (int r = 0; r < 3; r++) begin
            rom_req <= 3'h1 << r;
            for (int w = 0; w < 2; w++) begin
                rom_addr <= 72'(`MMB_ROM_SINE + 2 * w) << (24 * r);
                n = 0;
                do tick(); while (rom_ack[r] !== 1'b1 && n < 20);
                // take edge, busy cycles, then the edge that sees the ack pulse
                chk(n === (w ? `MMB_ROM_NEXT_CYC : `MMB_ROM_FIRST_CYC) + 2, "rom timing");
                chk(rom_rdata === 16'(q[w]) && rom_section === SEC_SINE, "rom word");
            end
            rom_req <= '0;
            repeat (2) @(posedge core_clk);
        end
        $display("rom test done");
        a = 24'h40_0000 + 24'($urandom_range(0, 'hFFFF));
        ic_addr <= a;
        for (int i = 0; i < 4; i++) begin
            slow <= i == 0;
            if (i == 2)
                // flush and freeze together: the refill must not allocate, so the last fetch misses too
                bus(1, `MMB_REG_STATUS3, 32'h0000_000E);
            ic_req <= 1;
            n = 0;
            do tick(); while (ic_ack !== 1'b1 && n < 40);
            chk(ic_ack === 1'b1 && ic_hit === (i == 1), "cache hit");
            chk(ic_data === {8'h00, a[23:4], 4'h0} + 32'(a[3:2]), "cache data");
            ic_req <= 0;
            @(posedge core_clk);
        end
        $display("cache test done");
        end_of_test();
    end
endmodule
